// [verilog/bridge_core_defs.vh]
`ifndef BRIDGE_CORE_DEFS_VH
`define BRIDGE_CORE_DEFS_VH
`define REG_RESTART 8'h09
`define REG_CLK_SRC 8'h0A
`define REG_CLK_SCALE 8'h0B
`define REG_SYNTH 8'h0D
`define REG_IN_MODE 8'h10
`define REG_IN_BAND 8'h12
`define REG_OUT_FMT 8'h18
`define REG_LANES 8'h13
`define BIT_RESTART 0
`define BIT_CLK_SRC 0
`define BIT_LOCK 7
`define BIT_SYNTH_EN 0
`define BIT_LINK_SINGLE 4
`define BIT_A_WIDE 3
`define BIT_A_LSB_FMT 1
`define BIT_B_LSB_FMT 0
`define BIT_LEFT_RIGHT 7
`define RESET_OUT_FMT 8'h10
`define RESET_ZERO 8'h00
`define RESET_LANES 8'h03
`define LOCK_CYCLES 16'h0010
`define FIFO_DEPTH 8
`endif

// [verilog/pixel_fifo.v]
`timescale 1ns/100ps
module pixel_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clock,
	input wire reset_n,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	localparam [AW:0] FULL_COUNT = DEPTH;
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_reg;
	reg [AW-1:0] rd_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;
	assign in_ready = (count_reg != FULL_COUNT);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always @(posedge clock) begin
		if (push)
			mem[wr_reg] <= in_data;
	end
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop)
				rd_reg <= rd_reg + 1'b1;
			if (push & ~pop)
				count_reg <= count_reg + 1'b1;
			else if (pop & ~push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule

// [verilog/lane_merge.v]
`timescale 1ns/100ps
// Round-robin byte merge across up to four aligned lanes.
module lane_merge (
	input wire clock,
	input wire reset_n,
	input wire flush,
	input wire [1:0] lane_count_m1,
	input wire [31:0] lane_bytes,
	input wire [3:0] lane_valid,
	output reg [7:0] byte_data,
	output reg byte_valid,
	input wire byte_ready,
	output wire lanes_taken
);
	reg [1:0] index_reg;
	reg [3:0] pending_reg;
	reg [31:0] hold_reg;
	wire [3:0] active_lanes;
	wire cur_has;
	wire [1:0] index_next;
	assign active_lanes = (lane_count_m1 == 2'd0) ? 4'b0001 : (lane_count_m1 == 2'd1) ? 4'b0011 :
		(lane_count_m1 == 2'd2) ? 4'b0111 : 4'b1111;
	assign cur_has = pending_reg[index_reg];
	assign index_next = (index_reg == lane_count_m1) ? 2'd0 : index_reg + 2'd1;
	// A beat is taken when nothing is pending; short beats close early on high lanes
	assign lanes_taken = (pending_reg == 4'b0000);
	always @* begin
		byte_data = hold_reg[index_reg*8 +: 8];
		byte_valid = cur_has;
	end
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			index_reg <= 2'd0;
			pending_reg <= 4'b0000;
			hold_reg <= 32'h0000_0000;
		end else if (flush) begin
			index_reg <= 2'd0;
			pending_reg <= 4'b0000;
		end else if (pending_reg == 4'b0000) begin
			if (|(lane_valid & active_lanes)) begin
				hold_reg <= lane_bytes;
				pending_reg <= lane_valid & active_lanes;
				index_reg <= 2'd0; // Byte k comes from lane k mod count, from lane 0
			end
		end else if (!cur_has) begin
			index_reg <= 2'd0;
			pending_reg <= 4'b0000;
		end else if (byte_ready) begin
			pending_reg[index_reg] <= 1'b0;
			index_reg <= index_next;
		end
	end
endmodule

// [verilog/bridge_core.v]
`timescale 1ns/100ps
`include "bridge_core_defs.vh"
module bridge_core (
	input wire clock,
	input wire reset_n,
	input wire cfg_write,
	input wire cfg_read,
	input wire [7:0] cfg_addr,
	input wire [7:0] cfg_wdata,
	output reg [7:0] cfg_rdata,
	input wire synth_locked,
	input wire [31:0] lane_bytes,
	input wire [3:0] lane_valid,
	input wire in_pixel_24,
	input wire in_vsync,
	input wire in_hsync,
	input wire pixel_tick,
	output reg synth_enable,
	output reg pixel_clock_source_sel,
	output reg [1:0] ref_clock_mult_factor,
	output reg [4:0] chan_a_clk_divider,
	output reg [2:0] output_clock_band,
	output reg [7:0] input_clock_band,
	output reg [27:0] chan_a_data,
	output reg [27:0] chan_b_data,
	output reg chan_a_fourth_data_pair_en,
	output reg chan_b_clock_en,
	output reg out_vsync,
	output reg out_hsync,
	output reg out_de
);
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_RUN = 3'b100;
	reg [7:0] restart_reg;
	reg [7:0] clk_src_reg;
	reg [7:0] clk_scale_reg;
	reg [7:0] synth_reg;
	reg [7:0] in_mode_reg;
	reg [7:0] in_band_reg;
	reg [7:0] out_fmt_reg;
	reg [7:0] lanes_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [1:0] lock_sync_reg;
	reg [1:0] vs_sync_reg;
	reg [1:0] hs_sync_reg;
	reg [1:0] tick_sync_reg;
	reg [1:0] bpp_sync_reg;
	reg tick_prev_reg;
	reg [15:0] lock_cnt_reg;
	reg restart_pulse_reg;
	reg [1:0] byte_idx_reg;
	reg [23:0] pix_acc_reg;
	reg pix_valid_reg;
	reg [23:0] odd_pix_reg;
	reg have_odd_reg;
	reg odd_next_reg;
	wire locked;
	wire tick;
	wire flush;
	wire [7:0] m_byte;
	wire m_valid;
	wire m_ready;
	wire f_in_ready;
	wire f_out_valid;
	wire [23:0] f_out_data;
	wire f_out_ready;
	wire link_single;
	wire a_wide;
	wire running;
	wire [1:0] bytes_per_pix;
	wire [23:0] pix_full;
	wire [23:0] cur_pix;
	wire [27:0] a_word;
	wire [27:0] b_word;
	assign locked = lock_sync_reg[1];
	assign tick = tick_sync_reg[1] & ~tick_prev_reg;
	assign link_single = out_fmt_reg[`BIT_LINK_SINGLE];
	assign a_wide = out_fmt_reg[`BIT_A_WIDE];
	assign running = (state_reg == ST_RUN);
	// Restart clears only pipeline state; all configuration registers hold
	assign flush = restart_pulse_reg;
	// Incoming pixels are 24 bit words; 18 bpp is taken as three bytes per pixel here
	assign bytes_per_pix = 2'd2;
	assign pix_full = bpp_sync_reg[1] ? {pix_acc_reg[15:0], m_byte} : {pix_acc_reg[15:0] & 16'hFCFC, m_byte & 8'hFC};
	assign m_ready = f_in_ready | (byte_idx_reg != bytes_per_pix);
	// Register file over the documented configuration port
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			restart_reg <= `RESET_ZERO;
			clk_src_reg <= `RESET_ZERO;
			clk_scale_reg <= `RESET_ZERO;
			synth_reg <= `RESET_ZERO;
			in_mode_reg <= `RESET_ZERO;
			in_band_reg <= `RESET_ZERO;
			out_fmt_reg <= `RESET_OUT_FMT;
			lanes_reg <= `RESET_LANES;
			restart_pulse_reg <= 1'b0;
		end else begin
			restart_pulse_reg <= 1'b0;
			if (cfg_write) begin
				case (cfg_addr)
				`REG_RESTART: restart_pulse_reg <= cfg_wdata[`BIT_RESTART]; // Self-clearing
				`REG_CLK_SRC: clk_src_reg <= {1'b0, 3'b000, cfg_wdata[3:0]};
				`REG_CLK_SCALE: clk_scale_reg <= {cfg_wdata[7:3], 1'b0, cfg_wdata[1:0]};
				`REG_SYNTH: synth_reg <= {7'h00, cfg_wdata[`BIT_SYNTH_EN]};
				`REG_IN_MODE: in_mode_reg <= {cfg_wdata[7:5], 5'h00};
				`REG_IN_BAND: in_band_reg <= cfg_wdata;
				`REG_OUT_FMT: out_fmt_reg <= {3'b000, cfg_wdata[4:3], 1'b0, cfg_wdata[1:0]};
				`REG_LANES: lanes_reg <= {6'h00, cfg_wdata[1:0]};
				default: ;
				endcase
			end
		end
	end
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cfg_rdata <= 8'h00;
		end else if (cfg_read) begin
			case (cfg_addr)
			`REG_RESTART: cfg_rdata <= 8'h00;
			`REG_CLK_SRC: cfg_rdata <= {locked, clk_src_reg[6:0]}; // Lock status read back
			`REG_CLK_SCALE: cfg_rdata <= clk_scale_reg;
			`REG_SYNTH: cfg_rdata <= synth_reg;
			`REG_IN_MODE: cfg_rdata <= in_mode_reg;
			`REG_IN_BAND: cfg_rdata <= in_band_reg;
			`REG_OUT_FMT: cfg_rdata <= out_fmt_reg;
			`REG_LANES: cfg_rdata <= lanes_reg;
			default: cfg_rdata <= 8'h00;
			endcase
		end
	end
	// Lock, sync, tick and bpp pins pass two flops first; lane and config inputs do not
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lock_sync_reg <= 2'b00;
			vs_sync_reg <= 2'b00;
			hs_sync_reg <= 2'b00;
			tick_sync_reg <= 2'b00;
			bpp_sync_reg <= 2'b00;
			tick_prev_reg <= 1'b0;
		end else begin
			lock_sync_reg <= {lock_sync_reg[0], synth_locked};
			vs_sync_reg <= {vs_sync_reg[0], in_vsync};
			hs_sync_reg <= {hs_sync_reg[0], in_hsync};
			tick_sync_reg <= {tick_sync_reg[0], pixel_tick};
			bpp_sync_reg <= {bpp_sync_reg[0], in_pixel_24};
			tick_prev_reg <= tick_sync_reg[1];
		end
	end
	// Output stays dead until synth locked and a restart arrives
	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: if (synth_reg[`BIT_SYNTH_EN]) state_next = ST_WAIT;
		ST_WAIT: if (!synth_reg[`BIT_SYNTH_EN]) state_next = ST_IDLE;
			else if (locked && lock_cnt_reg == `LOCK_CYCLES && restart_pulse_reg) state_next = ST_RUN;
		ST_RUN: if (!synth_reg[`BIT_SYNTH_EN] || !locked) state_next = ST_IDLE;
		default: state_next = ST_IDLE;
		endcase
	end
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			lock_cnt_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			// Lock must be steady for a while so a glitch cannot start output
			if (!locked)
				lock_cnt_reg <= 16'h0000;
			else if (lock_cnt_reg != `LOCK_CYCLES)
				lock_cnt_reg <= lock_cnt_reg + 16'h0001;
		end
	end
	// Clock steering outputs to the synthesizer
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			synth_enable <= 1'b0;
			pixel_clock_source_sel <= 1'b0;
			ref_clock_mult_factor <= 2'b00;
			chan_a_clk_divider <= 5'h00;
			output_clock_band <= 3'b000;
			input_clock_band <= 8'h00;
		end else begin
			synth_enable <= synth_reg[`BIT_SYNTH_EN];
			pixel_clock_source_sel <= clk_src_reg[`BIT_CLK_SRC];
			ref_clock_mult_factor <= clk_scale_reg[1:0];
			chan_a_clk_divider <= clk_scale_reg[7:3];
			output_clock_band <= clk_src_reg[3:1];
			input_clock_band <= in_band_reg;
		end
	end
	lane_merge merge (
		.clock(clock),
		.reset_n(reset_n),
		.flush(flush | ~running),
		.lane_count_m1(lanes_reg[1:0]),
		.lane_bytes(lane_bytes),
		.lane_valid(lane_valid),
		.byte_data(m_byte),
		.byte_valid(m_valid),
		.byte_ready(m_ready),
		.lanes_taken()
	);
	// Bytes pack into pixels, red first
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			byte_idx_reg <= 2'd0;
			pix_acc_reg <= 24'h00_0000;
		end else if (flush) begin
			byte_idx_reg <= 2'd0;
		end else if (m_valid && m_ready) begin
			pix_acc_reg <= {pix_acc_reg[15:0], m_byte};
			byte_idx_reg <= (byte_idx_reg == bytes_per_pix) ? 2'd0 : byte_idx_reg + 2'd1;
		end
	end
	always @* begin
		pix_valid_reg = m_valid && (byte_idx_reg == bytes_per_pix);
	end
	pixel_fifo #(.WIDTH(24), .DEPTH(`FIFO_DEPTH), .AW(3)) queue (
		.clock(clock),
		.reset_n(reset_n),
		.flush(flush),
		.in_valid(pix_valid_reg),
		.in_ready(f_in_ready),
		.in_data(pix_full),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);
	// The queue drains only on pixel ticks, so a slow panel stalls the lane merge; beats that arrive meanwhile are dropped
	assign f_out_ready = tick & running;
	// Empty queue or idle state sends zeros
	assign cur_pix = (running && f_out_valid) ? f_out_data : 24'h00_0000;
	function [27:0] map_word;
		input [23:0] p;
		input msb_fmt;
		input wide;
		begin
			// Six MSBs per colour on pairs 0-2, the remaining pair per format
			map_word[20:0] = {p[23:18], p[15:10], p[7:2], 3'b000};
			if (!wide)
				map_word[27:21] = 7'h00; // Fourth pair low, LSBs dropped
			else if (msb_fmt)
				map_word[27:21] = {1'b0, p[23:22], p[15:14], p[7:6]};
			else
				map_word[27:21] = {1'b0, p[1:0], p[9:8], p[17:16]};
		end
	endfunction
	assign a_word = map_word(link_single ? cur_pix : odd_pix_reg, ~out_fmt_reg[`BIT_A_LSB_FMT], a_wide);
	assign b_word = map_word(cur_pix, ~out_fmt_reg[`BIT_B_LSB_FMT], a_wide);
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			chan_a_data <= 28'h000_0000;
			chan_b_data <= 28'h000_0000;
			chan_a_fourth_data_pair_en <= 1'b0;
			chan_b_clock_en <= 1'b0;
			out_vsync <= 1'b0;
			out_hsync <= 1'b0;
			out_de <= 1'b0;
			odd_pix_reg <= 24'h00_0000;
			have_odd_reg <= 1'b0;
			odd_next_reg <= 1'b1;
		end else begin
			out_vsync <= vs_sync_reg[1]; // Sync keeps flowing with zero data
			out_hsync <= hs_sync_reg[1];
			chan_a_fourth_data_pair_en <= running & a_wide;
			chan_b_clock_en <= running & ~link_single;
			if (flush) begin
				have_odd_reg <= 1'b0;
				odd_next_reg <= 1'b1;
			end else if (tick) begin
				if (link_single) begin
					chan_a_data <= a_word;
					chan_b_data <= 28'h000_0000;
					out_de <= running & f_out_valid;
				end else if (odd_next_reg) begin
					// Pixel 1, 3, 5... waits to pair with the following even one
					odd_pix_reg <= cur_pix;
					have_odd_reg <= running & f_out_valid;
					odd_next_reg <= ~(running & f_out_valid);
					out_de <= 1'b0;
					if (!(running & f_out_valid)) begin
						chan_a_data <= 28'h000_0000; // Nothing queued, so both links idle at zero
						chan_b_data <= 28'h000_0000;
					end
				end else begin
					chan_a_data <= a_word; // Odd on A
					chan_b_data <= b_word; // Even on B
					out_de <= have_odd_reg;
					odd_next_reg <= 1'b1;
				end
			end
		end
	end
endmodule

// [verification/bridge_core_props.sv]
`timescale 1ns/100ps
module bridge_core_props (
	input wire clock,
	input wire reset_n,
	input wire cfg_write,
	input wire [7:0] cfg_addr,
	input wire [7:0] cfg_wdata,
	input wire pixel_tick,
	input wire synth_enable,
	input wire pixel_clock_source_sel,
	input wire [1:0] ref_clock_mult_factor,
	input wire [4:0] chan_a_clk_divider,
	input wire [2:0] output_clock_band,
	input wire [27:0] chan_b_data,
	input wire [27:0] chan_a_data,
	input wire chan_a_fourth_data_pair_en,
	input wire chan_b_clock_en,
	input wire out_de
);
	reg [7:0] fmt_reg;
	reg started_reg;
	reg [1:0] ticks_reg;
	reg tick_d_reg;
	// Outputs only settle a few pixel slots after a format change
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fmt_reg <= 8'h10;
			started_reg <= 1'b0;
			ticks_reg <= 2'd0;
			tick_d_reg <= 1'b0;
		end else begin
			tick_d_reg <= pixel_tick;
			if (cfg_write && cfg_addr == 8'h18) begin
				fmt_reg <= cfg_wdata;
				ticks_reg <= 2'd0;
			end else if (pixel_tick && !tick_d_reg && ticks_reg != 2'd3) begin
				ticks_reg <= ticks_reg + 2'd1;
			end
			if (cfg_write && cfg_addr == 8'h09 && cfg_wdata[0]) begin
				started_reg <= 1'b1;
			end
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_wr(a);
		cfg_write && cfg_addr == a ##1 (!cfg_write) [*2];
	endsequence
	property p_synth; s_wr(8'h0D) |-> synth_enable == $past(cfg_wdata[0], 2); endproperty
	a_synth: assert property (p_synth) else $error("synth enable mismatch");
	property p_src; s_wr(8'h0A) |-> pixel_clock_source_sel == $past(cfg_wdata[0], 2); endproperty
	a_src: assert property (p_src) else $error("clock source mismatch");
	property p_mult; s_wr(8'h0B) |-> ref_clock_mult_factor == $past(cfg_wdata[1:0], 2); endproperty
	a_mult: assert property (p_mult) else $error("multiplier mismatch");
	property p_div; s_wr(8'h0B) |-> chan_a_clk_divider == $past(cfg_wdata[7:3], 2); endproperty
	a_div: assert property (p_div) else $error("divider mismatch");
	property p_band; s_wr(8'h0A) |-> output_clock_band == $past(cfg_wdata[3:1], 2); endproperty
	a_band: assert property (p_band) else $error("output band mismatch");
	property p_single; fmt_reg[4] && ticks_reg == 2'd3 |-> !chan_b_clock_en && chan_b_data == 28'h0; endproperty
	a_single: assert property (p_single) else $error("channel b active in single link");
	property p_narrow; !fmt_reg[3] && ticks_reg == 2'd3 |-> !chan_a_fourth_data_pair_en && chan_a_data[27:21] == 7'h00;
	endproperty
	a_narrow: assert property (p_narrow) else $error("fourth pair active in narrow mode");
	property p_idle; !started_reg |-> !out_de; endproperty
	a_idle: assert property (p_idle) else $error("video before restart");
	property p_keep; cfg_write && cfg_addr == 8'h09 |=> $stable(chan_a_clk_divider) && $stable(ref_clock_mult_factor);
	endproperty
	a_keep: assert property (p_keep) else $error("restart altered clock setup");
endmodule
bind bridge_core bridge_core_props u_props (.*);

// [verification/host_lane_model.sv]
`timescale 1ns/100ps
module host_lane_model (
	input wire clock,
	output reg [31:0] lane_bytes,
	output reg [3:0] lane_valid
);
	initial begin
		lane_bytes = 32'h0000_0000;
		lane_valid = 4'h0;
	end
	// One beat, then lanes plus gap plus one idle clocks before the next beat; a larger gap models a slow host
	task send(input [63:0] pkt, input integer n, input integer lanes, input integer gap);
		integer k;
		integer l;
		reg [31:0] b;
		reg [3:0] v;
		begin
			k = 0;
			while (k < n) begin
				b = ~lane_bytes;
				v = 4'h0;
				for (l = 0; l < lanes; l = l + 1) begin
					if (k < n) begin
						b[8*l +: 8] = pkt[8*k +: 8];
						v[l] = 1'b1;
						k = k + 1;
					end
				end
				@(posedge clock);
				#1;
				lane_bytes = b;
				lane_valid = v;
				@(posedge clock);
				#1;
				lane_valid = 4'h0;
				lane_bytes = ~b;
				repeat (lanes + gap) @(posedge clock);
			end
		end
	endtask
endmodule

// [verification/bridge_core_tb_top.sv]
`timescale 1ns/100ps
module bridge_core_tb_top;
	reg clock = 1'b0;
	reg reset_n = 1'b0;
	reg cfg_write = 1'b0;
	reg cfg_read = 1'b0;
	reg [7:0] cfg_addr = 8'h00;
	reg [7:0] cfg_wdata = 8'h00;
	reg synth_locked = 1'b0;
	reg in_pixel_24 = 1'b1;
	reg in_vsync = 1'b0;
	reg in_hsync = 1'b0;
	reg pixel_tick = 1'b0;
	reg [2:0] tick_div = 3'd0;
	wire [7:0] cfg_rdata;
	wire [31:0] lane_bytes;
	wire [3:0] lane_valid;
	wire synth_enable, pixel_clock_source_sel, chan_a_fourth_data_pair_en, chan_b_clock_en;
	wire out_vsync, out_hsync, out_de;
	wire [1:0] ref_clock_mult_factor;
	wire [4:0] chan_a_clk_divider;
	wire [2:0] output_clock_band;
	wire [7:0] input_clock_band;
	wire [27:0] chan_a_data, chan_b_data;
	integer fail_count = 0;
	integer checks_done = 0;
	integer i;
	always #5 clock = ~clock;
	always @(posedge clock) begin
		#1;
		tick_div = tick_div + 3'd1;
		pixel_tick = tick_div[2];
	end
	bridge_core u_dut (.*);
	host_lane_model u_host (.clock(clock), .lane_bytes(lane_bytes), .lane_valid(lane_valid));
	task check(input string name, input [31:0] exp, input [31:0] got);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[FAIL] %s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clock);
			#1;
			cfg_write = 1'b1;
			cfg_addr = a;
			cfg_wdata = d;
			@(posedge clock);
			#1;
			cfg_write = 1'b0;
			repeat (2) @(posedge clock);
			#1;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge clock);
			#1;
			cfg_read = 1'b1;
			cfg_addr = a;
			@(posedge clock);
			#1;
			cfg_read = 1'b0;
		end
	endtask
	task start_run;
		begin
			wr(8'h0D, 8'h01);
			check("synth_enable", 1, synth_enable);
			synth_locked = 1'b1;
			i = 0;
			rd(8'h0A);
			while (cfg_rdata[7] !== 1'b1 && i < 20) begin
				rd(8'h0A);
				i = i + 1;
			end
			check("lock", 1, cfg_rdata[7]);
			// Lock must stay stable before the restart is accepted
			repeat (20) @(posedge clock);
			#1;
			wr(8'h09, 8'h01);
		end
	endtask
	task run_video(input [7:0] fmt, input [7:0] lanes_m1, input integer lanes, input integer gap, input [63:0] pkt);
		begin
			wr(8'h18, fmt);
			wr(8'h13, lanes_m1);
			start_run;
			u_host.send(pkt, (fmt[4] ? 3 : 6), lanes, gap);
			i = 0;
			while (out_de !== 1'b1 && i < 400) begin
				@(posedge clock);
				#1;
				i = i + 1;
			end
			check("out_de", 1, out_de);
		end
	endtask
	task t_reset;
		begin
			rd(8'h18);
			check("out_fmt", 8'h10, cfg_rdata);
			rd(8'h0D);
			check("synth_ctrl", 8'h00, cfg_rdata);
			rd(8'h13);
			check("lanes", 8'h03, cfg_rdata);
			rd(8'h40);
			check("unmapped", 8'h00, cfg_rdata);
			check("de_idle", 0, out_de);
		end
	endtask
	task t_clocks;
		begin
			wr(8'h0A, 8'h0B); // Input clock lane stays in high-speed while it sources pixels
			wr(8'h0B, 8'hAB);
			wr(8'h12, 8'h5A);
			wr(8'h10, 8'hE0);
			rd(8'h10);
			check("in_mode", 8'hE0, cfg_rdata);
			check("src", 1, pixel_clock_source_sel);
			check("mult", 3, ref_clock_mult_factor);
			check("div", 5'h15, chan_a_clk_divider);
			check("out_band", 3'h5, output_clock_band);
			check("in_band", 8'h5A, input_clock_band);
			wr(8'h0A, 8'h00); // Reference selected; the model's reference lies within 25 to 154 MHz
			check("src_ref", 0, pixel_clock_source_sel);
		end
	endtask
	task t_blank;
		begin
			in_hsync = 1'b1;
			in_vsync = 1'b1;
			repeat (40) @(posedge clock);
			#1;
			check("hsync", 1, out_hsync);
			check("vsync", 1, out_vsync);
			check("blank_a", 0, chan_a_data);
			check("blank_b", 0, chan_b_data);
			in_hsync = 1'b0;
			repeat (40) @(posedge clock);
			#1;
			check("hsync_low", 0, out_hsync);
		end
	endtask
	task t_dual;
		begin
			run_video(8'h0B, 8'h03, 4, 1, 64'h0000_FCFC_FC03_0303);
			check("a_lsb_pair", 1, chan_a_data[27:21] != 7'h00);
			check("b_lsb_pair", 0, chan_b_data[27:21]);
			check("b_clock", 1, chan_b_clock_en);
			run_video(8'h08, 8'h02, 3, 2, 64'h0000_FCFC_FC03_0303);
			check("a_msb_pair", 0, chan_a_data[27:21]);
			check("b_msb_pair", 1, chan_b_data[27:21] != 7'h00);
		end
	endtask
	task t_narrow;
		begin
			// 18 bpp input: the core zeroes the low colour bits, so the LSB pair stays zero
			in_pixel_24 = 1'b0;
			run_video(8'h1A, 8'h00, 1, 2, 64'h0000_0000_00FF_FFFF);
			check("pair18", 0, chan_a_data[27:21]);
			check("pair18_en", 1, chan_a_fourth_data_pair_en);
			check("colour18", 1, chan_a_data[20:0] != 21'h0);
			in_pixel_24 = 1'b1;
			run_video(8'h12, 8'h00, 1, 2, 64'h0000_0000_00FF_FFFF);
			check("pair_en", 0, chan_a_fourth_data_pair_en);
			check("a_pair3", 0, chan_a_data[27:21]);
			check("a_colour", 1, chan_a_data[20:0] != 21'h0);
			check("b_data", 0, chan_b_data);
			rd(8'h0B);
			check("scale_kept", 8'hAB, cfg_rdata);
		end
	endtask
	task print_verdict;
		begin
			if (fail_count == 0 && checks_done > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask
	initial begin
		repeat (4) @(posedge clock);
		#1;
		reset_n = 1'b1;
		// Regulator settling after enable is shortened to keep the run brief
		repeat (4) @(posedge clock);
		#1;
		t_reset;
		t_clocks;
		t_blank;
		t_dual;
		t_narrow;
		print_verdict;
	end
	initial begin
		#300000;
		fail_count = fail_count + 1;
		print_verdict;
	end
endmodule
